/* File: rtl/bvsr_pkg.sv */
`default_nettype none
package bvsr_pkg;

	// register map and layout
	localparam logic [7:0] ADDR_SECOND   = 8'h0F;
	localparam logic [7:0] ADDR_THIRD    = 8'h10;
	localparam logic [7:0] SETPOINT_RST  = 8'h08;
	localparam int         XADJ_BIT      = 7;
	localparam int         RSVD_BIT      = 6;
	localparam int         CODE_W        = 6;
	localparam int         MV_W          = 12;
	localparam logic [7:0] RDATA_RST     = 8'h00;
	// programmable code bits: second drops bit 0, third bits 5 and 0
	localparam logic [5:0] SECOND_MASK   = 6'h3E;
	localparam logic [5:0] THIRD_MASK    = 6'h1E;

	// code segment starts
	localparam logic [5:0] SEG1_START    = 6'h10;
	localparam logic [5:0] SEG2_START    = 6'h18;
	localparam logic [5:0] SEG3_START    = 6'h30;
	localparam logic [5:0] CODE_3V0      = 6'h35;
	localparam logic [5:0] CODE_3V1      = 6'h36;
	localparam logic [5:0] CODE_3V2      = 6'h37;

	// voltages in millivolts
	localparam logic [11:0] MV_BASE0     = 12'h384; // 0.9 V
	localparam logic [11:0] MV_BASE1     = 12'h514; // 1.3 V
	localparam logic [11:0] MV_BASE2     = 12'h5DC; // 1.5 V
	localparam logic [11:0] MV_BASE3     = 12'hA8C; // 2.7 V
	localparam logic [11:0] MV_3V0       = 12'hBB8;
	localparam logic [11:0] MV_3V1       = 12'hC1C;
	localparam logic [11:0] MV_3V2       = 12'hC80;
	localparam logic [11:0] MV_TOP       = 12'hCE4; // 3.3 V
	localparam logic [11:0] MV_FINE      = 12'h019; // 25 mV step
	localparam logic [11:0] MV_COARSE    = 12'h032; // 50 mV step
	localparam logic [11:0] MV_EXTERNAL  = 12'h000;

	// one segment of the linear code ladder
	function automatic logic [11:0] seg_mv(
		input logic [11:0] base,
		input logic [11:0] step,
		input logic [5:0]  code,
		input logic [5:0]  start
	);
		logic [5:0] off;
		off = code - start;
		return base + step * {6'h00, off};
	endfunction : seg_mv

	// voltage code to millivolts
	function automatic logic [11:0] code_to_mv(input logic [5:0] code);
		logic [11:0] mv;
		if (code < SEG1_START)
			mv = seg_mv(MV_BASE0, MV_FINE, code, 6'h00);
		else if (code < SEG2_START)
			mv = seg_mv(MV_BASE1, MV_FINE, code, SEG1_START);
		else if (code < SEG3_START)
			mv = seg_mv(MV_BASE2, MV_COARSE, code, SEG2_START);
		else if (code < CODE_3V0)
			mv = seg_mv(MV_BASE3, MV_COARSE, code, SEG3_START);
		else if (code == CODE_3V0)
			mv = MV_3V0;
		else if (code == CODE_3V1)
			mv = MV_3V1;
		else if (code == CODE_3V2)
			mv = MV_3V2;
		else
			mv = MV_TOP;
		return mv;
	endfunction : code_to_mv

endpackage : bvsr_pkg
`default_nettype wire

/* File: rtl/bvsr_setpoint_chan.sv */
`timescale 1ns/10ps
`default_nettype none
module bvsr_setpoint_chan #(
	parameter logic [5:0] CODE_MASK = bvsr_pkg::SECOND_MASK
) (
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	// accepted write to this register
	input  wire logic        wr_i,
	input  wire logic [7:0]  wdata_i,
	// setpoint state
	output logic             ext_adjust_o,
	output logic [5:0]       code_o,
	output logic [11:0]      target_mv_o
);

	logic        xadj_r;
	logic        xadj_nxt;
	logic [5:0]  code_r;
	logic [5:0]  code_nxt;
	logic [11:0] mv_r;
	logic [11:0] mv_nxt;

	// fixed code bits are forced back to their reset value on every write
	always_comb
	begin
		xadj_nxt = xadj_r;
		code_nxt = code_r;
		if (wr_i)
		begin
			xadj_nxt = wdata_i[bvsr_pkg::XADJ_BIT];
			code_nxt = (wdata_i[5:0] & CODE_MASK)
				| (bvsr_pkg::SETPOINT_RST[5:0] & ~CODE_MASK);
		end
		// external adjust means the code does not set the output
		mv_nxt = xadj_r ? bvsr_pkg::MV_EXTERNAL
			: bvsr_pkg::code_to_mv(code_r);
	end

	// register stage
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			xadj_r <= 1'b0;
			code_r <= bvsr_pkg::SETPOINT_RST[5:0];
			mv_r   <= bvsr_pkg::code_to_mv(bvsr_pkg::SETPOINT_RST[5:0]);
		end
		else
		begin
			xadj_r <= xadj_nxt;
			code_r <= code_nxt;
			mv_r   <= mv_nxt;
		end
	end

	assign ext_adjust_o = xadj_r;
	assign code_o       = code_r;
	assign target_mv_o  = mv_r;

endmodule : bvsr_setpoint_chan
`default_nettype wire

/* File: rtl/bvsr_regs.sv */
`timescale 1ns/10ps
`default_nettype none
module bvsr_regs (
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	// register access from the serial control interface
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_wr_unlocked_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_rd_i,
	output logic [7:0]       reg_rdata_o,
	output logic             reg_wr_refused_o,
	// second converter setpoint
	output logic             second_buck_external_adjust_o,
	output logic [5:0]       second_buck_voltage_code_o,
	output logic [11:0]      second_buck_target_mv_o,
	// third converter setpoint
	output logic             third_buck_external_adjust_o,
	output logic [5:0]       third_buck_voltage_code_o,
	output logic [11:0]      third_buck_target_mv_o
);

	logic       hit_second;
	logic       hit_third;
	logic       wr_second;
	logic       wr_third;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic       refused_r;
	logic       refused_nxt;

	// pack a setpoint into its read image, reserved bit forced low
	function automatic logic [7:0] pack_setpoint(
		input logic       xadj,
		input logic [5:0] code
	);
		logic [7:0] img;
		img = {xadj, 1'b0, code};
		return img;
	endfunction : pack_setpoint

	// address decode
	always_comb
	begin
		hit_second = 1'b0;
		hit_third  = 1'b0;
		if (reg_addr_i == bvsr_pkg::ADDR_SECOND)
			hit_second = 1'b1;
		else if (reg_addr_i == bvsr_pkg::ADDR_THIRD)
			hit_third = 1'b1;
	end

	// a write only lands when the password procedure has unlocked it
	assign wr_second = reg_wr_i & reg_wr_unlocked_i & hit_second;
	assign wr_third  = reg_wr_i & reg_wr_unlocked_i & hit_third;

	// the two setpoint registers
	bvsr_setpoint_chan #(
		.CODE_MASK (bvsr_pkg::SECOND_MASK)
	) u_second (
		.ref_clk_i    (ref_clk_i),
		.rst_i        (rst_i),
		.wr_i         (wr_second),
		.wdata_i      (reg_wdata_i),
		.ext_adjust_o (second_buck_external_adjust_o),
		.code_o       (second_buck_voltage_code_o),
		.target_mv_o  (second_buck_target_mv_o)
	);

	bvsr_setpoint_chan #(
		.CODE_MASK (bvsr_pkg::THIRD_MASK)
	) u_third (
		.ref_clk_i    (ref_clk_i),
		.rst_i        (rst_i),
		.wr_i         (wr_third),
		.wdata_i      (reg_wdata_i),
		.ext_adjust_o (third_buck_external_adjust_o),
		.code_o       (third_buck_voltage_code_o),
		.target_mv_o  (third_buck_target_mv_o)
	);

	// read path; read data holds until the next read so the serial
	// shifter may take it at leisure; unmapped addresses read zero
	always_comb
	begin
		rdata_nxt = rdata_r;
		if (reg_rd_i)
		begin
			if (hit_second)
				rdata_nxt = pack_setpoint(second_buck_external_adjust_o,
					second_buck_voltage_code_o);
			else if (hit_third)
				rdata_nxt = pack_setpoint(third_buck_external_adjust_o,
					third_buck_voltage_code_o);
			else
				rdata_nxt = bvsr_pkg::RDATA_RST;
		end
		// locked write to a setpoint is dropped and flagged for one cycle
		refused_nxt = reg_wr_i & ~reg_wr_unlocked_i
			& (hit_second | hit_third);
	end

	// register stage
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			rdata_r   <= bvsr_pkg::RDATA_RST;
			refused_r <= 1'b0;
		end
		else
		begin
			rdata_r   <= rdata_nxt;
			refused_r <= refused_nxt;
		end
	end

	assign reg_rdata_o      = rdata_r;
	assign reg_wr_refused_o = refused_r;

	// checks
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_open_wr_second;
		reg_wr_i && reg_wr_unlocked_i
			&& reg_addr_i == bvsr_pkg::ADDR_SECOND;
	endsequence

	sequence s_open_wr_third;
		reg_wr_i && reg_wr_unlocked_i
			&& reg_addr_i == bvsr_pkg::ADDR_THIRD;
	endsequence

	// only the two setpoint addresses raise the refusal flag
	sequence s_locked_wr;
		reg_wr_i && !reg_wr_unlocked_i
			&& (reg_addr_i == bvsr_pkg::ADDR_SECOND
			|| reg_addr_i == bvsr_pkg::ADDR_THIRD);
	endsequence

	property p_reset_vals;
		@(posedge ref_clk_i) disable iff (1'b0)
		rst_i |=> second_buck_voltage_code_o == bvsr_pkg::SETPOINT_RST[5:0]
			&& third_buck_voltage_code_o == bvsr_pkg::SETPOINT_RST[5:0]
			&& !second_buck_external_adjust_o
			&& !third_buck_external_adjust_o;
	endproperty

	chk_reset_values: assert property (p_reset_vals)
		else $error("setpoint reset value wrong");

	chk_locked_hold: assert property (
		s_locked_wr |=> $stable(second_buck_voltage_code_o)
			&& $stable(third_buck_voltage_code_o)
			&& $stable(second_buck_external_adjust_o)
			&& $stable(third_buck_external_adjust_o) && reg_wr_refused_o)
		else $error("locked write changed a setpoint");

	chk_second_write: assert property (
		s_open_wr_second |=> second_buck_voltage_code_o
			== ($past(reg_wdata_i[5:0]) & bvsr_pkg::SECOND_MASK)
			&& second_buck_external_adjust_o
			== $past(reg_wdata_i[bvsr_pkg::XADJ_BIT]))
		else $error("second setpoint write not taken");

	chk_third_write: assert property (
		s_open_wr_third |=> third_buck_voltage_code_o
			== ($past(reg_wdata_i[5:0]) & bvsr_pkg::THIRD_MASK)
			&& third_buck_external_adjust_o
			== $past(reg_wdata_i[bvsr_pkg::XADJ_BIT]))
		else $error("third setpoint write not taken");

	chk_second_lsb: assert property (
		!second_buck_voltage_code_o[0])
		else $error("second code bit 0 not zero");

	chk_third_fixed: assert property (
		!third_buck_voltage_code_o[5] && !third_buck_voltage_code_o[0])
		else $error("third code fixed bits not zero");

	chk_read_image: assert property (
		reg_rd_i && reg_addr_i == bvsr_pkg::ADDR_THIRD
		|=> reg_rdata_o == {$past(third_buck_external_adjust_o), 1'b0,
			$past(third_buck_voltage_code_o)} ##1 reg_rdata_o == $past(reg_rdata_o)
			|| $past(reg_rd_i))
		else $error("third read image wrong");

	chk_rsvd_read: assert property (
		reg_rd_i && reg_addr_i == bvsr_pkg::ADDR_SECOND
		|=> !reg_rdata_o[bvsr_pkg::RSVD_BIT]
			&& reg_rdata_o[5:0] == $past(second_buck_voltage_code_o))
		else $error("reserved bit read nonzero");

	chk_mv_follow: assert property (
		!second_buck_external_adjust_o ##1 !$past(rst_i)
		|-> second_buck_target_mv_o
			== bvsr_pkg::code_to_mv($past(second_buck_voltage_code_o)))
		else $error("second target voltage mismatch");

	chk_ext_ignore: assert property (
		s_open_wr_third ##1 third_buck_external_adjust_o
		|=> third_buck_target_mv_o == bvsr_pkg::MV_EXTERNAL)
		else $error("external adjust did not override code");

endmodule : bvsr_regs
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
// one compare: counts, and reports a mismatch at once
`define CHK(got, exp, msg) \
	begin \
		total_checks++; \
		if ((got) !== (exp)) \
		begin \
			errors++; \
			$display("ERROR %0t: %s got %h exp %h", $time, msg, got, exp); \
		end \
	end
module tb_top;
	// design inputs and outputs
	logic        ref_clk_i;
	logic        rst_i;
	logic [7:0]  reg_addr_i;
	logic        reg_wr_i;
	logic        reg_wr_unlocked_i;
	logic [7:0]  reg_wdata_i;
	logic        reg_rd_i;
	logic [7:0]  reg_rdata_o;
	logic        reg_wr_refused_o;
	logic        sec_adj;
	logic [5:0]  sec_code;
	logic [11:0] sec_mv;
	logic        thr_adj;
	logic [5:0]  thr_code;
	logic [11:0] thr_mv;
	int          errors;
	int          total_checks;

	bvsr_regs dut (
		.ref_clk_i                     (ref_clk_i),
		.rst_i                         (rst_i),
		.reg_addr_i                    (reg_addr_i),
		.reg_wr_i                      (reg_wr_i),
		.reg_wr_unlocked_i             (reg_wr_unlocked_i),
		.reg_wdata_i                   (reg_wdata_i),
		.reg_rd_i                      (reg_rd_i),
		.reg_rdata_o                   (reg_rdata_o),
		.reg_wr_refused_o              (reg_wr_refused_o),
		.second_buck_external_adjust_o (sec_adj),
		.second_buck_voltage_code_o    (sec_code),
		.second_buck_target_mv_o       (sec_mv),
		.third_buck_external_adjust_o  (thr_adj),
		.third_buck_voltage_code_o     (thr_code),
		.third_buck_target_mv_o        (thr_mv)
	);

	// free-running 10 MHz clock
	always #50 ref_clk_i = ~ref_clk_i;

	// independent ladder: kept apart from the design's own function
	function automatic logic [11:0] exp_mv(input int c);
		if (c < 16)
			return 12'(900 + 25 * c);
		else if (c < 24)
			return 12'(1300 + 25 * (c - 16));
		else if (c < 48)
			return 12'(1500 + 50 * (c - 24));
		else if (c < 53)
			return 12'(2700 + 50 * (c - 48));
		else if (c < 56)
			return 12'(3000 + 100 * (c - 53));
		else
			return 12'(3300);
	endfunction : exp_mv

	// one write strobe; the strobe drops just after the edge that takes it
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d,
		input logic unl);
		@(posedge ref_clk_i);
		#1;
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_unlocked_i = unl;
		reg_wr_i = 1'b1;
		@(posedge ref_clk_i);
		#1;
		reg_wr_i = 1'b0;
	endtask : wr_reg

	// one read strobe; data is settled on the same edge that takes it
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk_i);
		#1;
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(posedge ref_clk_i);
		#1;
		reg_rd_i = 1'b0;
		d = reg_rdata_o;
	endtask : rd_reg

	// both setpoints come up at code 8, register mode
	task automatic t_reset;
		logic [7:0] d;
		`CHK(sec_code, 6'h08, "second reset code")
		`CHK(thr_code, 6'h08, "third reset code")
		`CHK(sec_adj, 1'b0, "second reset adjust")
		`CHK(sec_mv, 12'h44C, "second reset mv")
		`CHK(thr_adj, 1'b0, "third reset adjust")
		`CHK(thr_mv, 12'h44C, "third reset mv")
		`CHK(reg_rdata_o, 8'h00, "reset read data")
		`CHK(reg_wr_refused_o, 1'b0, "reset refused flag")
		rd_reg(8'h0F, d);
		`CHK(d, 8'h08, "second reset read")
		rd_reg(8'h10, d);
		`CHK(d, 8'h08, "third reset read")
	endtask : t_reset

	// all ones written: reserved and fixed bits must stay clear
	task automatic t_fields;
		logic [7:0] d;
		wr_reg(8'h0F, 8'hFF, 1'b1);
		`CHK(sec_code, 6'h3E, "second fixed bit")
		`CHK(sec_adj, 1'b1, "second adjust set")
		`CHK(reg_wr_refused_o, 1'b0, "unlocked not refused")
		@(posedge ref_clk_i);
		#1;
		`CHK(sec_mv, 12'h000, "external mode mv")
		rd_reg(8'h0F, d);
		`CHK(d, 8'hBE, "second image")
		wr_reg(8'h10, 8'hFF, 1'b1);
		`CHK(thr_code, 6'h1E, "third fixed bits")
		rd_reg(8'h10, d);
		`CHK(d, 8'h9E, "third image")
		`CHK(thr_mv, 12'h000, "third external mv")
	endtask : t_fields

	// a locked write is refused for one cycle and changes nothing
	task automatic t_locked;
		wr_reg(8'h10, 8'h00, 1'b0);
		`CHK(reg_wr_refused_o, 1'b1, "refused pulse")
		`CHK(thr_code, 6'h1E, "locked code kept")
		@(posedge ref_clk_i);
		#1;
		`CHK(reg_wr_refused_o, 1'b0, "refused one cycle")
		`CHK(thr_adj, 1'b1, "locked adjust kept")
	endtask : t_locked

	// neighbour address is outside this bank
	task automatic t_unmapped;
		logic [7:0] d;
		wr_reg(8'h11, 8'h00, 1'b1);
		`CHK(sec_code, 6'h3E, "unmapped write ignored")
		wr_reg(8'h11, 8'h00, 1'b0);
		`CHK(reg_wr_refused_o, 1'b0, "unmapped not refused")
		rd_reg(8'h11, d);
		`CHK(d, 8'h00, "unmapped read zero")
	endtask : t_unmapped

	// reset in mid-run brings both setpoints and read data back
	task automatic t_midreset;
		logic [7:0] d;
		wr_reg(8'h0F, 8'h94, 1'b1);
		`CHK(sec_code, 6'h14, "second code before reset")
		@(posedge ref_clk_i);
		#1;
		rst_i = 1'b1;
		repeat (2) @(posedge ref_clk_i);
		#1;
		rst_i = 1'b0;
		`CHK(sec_code, 6'h08, "second code after reset")
		`CHK(thr_code, 6'h08, "third code after reset")
		`CHK(sec_adj, 1'b0, "second adjust after reset")
		`CHK(sec_mv, 12'h44C, "second mv after reset")
		`CHK(thr_mv, 12'h44C, "third mv after reset")
		`CHK(reg_rdata_o, 8'h00, "read data after reset")
		rd_reg(8'h0F, d);
		`CHK(d, 8'h08, "second read after reset")
	endtask : t_midreset

	// sweep every even code through both registers
	task automatic t_ladder;
		logic [7:0] d;
		for (int c = 0; c < 64; c += 2)
		begin
			wr_reg(8'h0F, 8'(c), 1'b1);
			wr_reg(8'h10, 8'(c), 1'b1);
			@(posedge ref_clk_i);
			#1;
			`CHK(sec_code, 6'(c), "second code")
			`CHK(sec_mv, exp_mv(c), "second mv")
			`CHK(thr_code, 6'(c & 30), "third code")
			`CHK(thr_mv, exp_mv(c & 30), "third mv")
		end
		rd_reg(8'h0F, d);
		`CHK(d, 8'h3E, "second top read")
	endtask : t_ladder

	// verdict and end of run
	task automatic report_and_stop;
		if (errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop

	// main sequence
	initial
	begin
		errors = 0;
		total_checks = 0;
		ref_clk_i = 1'b0;
		rst_i = 1'b1;
		reg_addr_i = 8'h00;
		reg_wr_i = 1'b0;
		reg_wr_unlocked_i = 1'b0;
		reg_wdata_i = 8'h00;
		reg_rd_i = 1'b0;
		repeat (6) @(posedge ref_clk_i);
		#1;
		rst_i = 1'b0;
		t_reset();
		t_fields();
		t_locked();
		t_unmapped();
		t_ladder();
		t_midreset();
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
